//--- logic/record_info_pkg.sv
// Purpose: shared constants of the record information register bank
// Assumes: 16-bit registers addressed by 7-bit byte address over the serial port
// Notes:   even address is the low byte, odd address the high byte of a register
package record_info_pkg;

  // register byte addresses (even byte of each 16-bit word)
  localparam logic [6:0] ADDR_CAPTURE_TIME_LOW          = 7'h4C;
  localparam logic [6:0] ADDR_CAPTURE_TIME_HIGH         = 7'h4E;
  localparam logic [6:0] ADDR_DAY_AND_FIRMWARE_REVISION = 7'h52;
  localparam logic [6:0] ADDR_YEAR_AND_MONTH            = 7'h54;
  localparam logic [6:0] ADDR_PRODUCT_CODE              = 7'h56;
  localparam logic [6:0] ADDR_UNIT_SERIAL               = 7'h58;
  localparam logic [6:0] ADDR_RECORD_FLASH_WEAR_COUNTER = 7'h5C;
  localparam logic [6:0] ADDR_MISCELLANEOUS_CONTROL     = 7'h64;
  localparam logic [6:0] ADDR_SPECTRAL_RECORD_SETTINGS  = 7'h66;
  localparam logic [6:0] ADDR_SPECTRAL_RECORD_AVG       = 7'h68;

  // reset values
  localparam logic [15:0] RESET_WORD = 16'h0000;

  // serial frame layout: write flag, address, data byte
  localparam int FRAME_BITS     = 16;
  localparam int FRAME_WR_BIT   = 15;
  localparam int FRAME_ADDR_MSB = 14;
  localparam int FRAME_ADDR_LSB = 8;

  // miscellaneous control bit positions
  localparam int MISC_SYNC_EN_BIT     = 12;
  localparam int MISC_STATS_LOAD_BIT  = 10;
  localparam int MISC_STATS_SAVE_BIT  = 9;
  localparam int MISC_STATS_CLEAR_BIT = 8;
  localparam int MISC_SELFTEST_ON_BIT = 3;
  localparam int MISC_SELFTEST_CLR_BIT = 2;
  localparam logic [15:0] MISC_READ_MASK = 16'h1000;

  // spectral record settings fields
  localparam int INFO_RATE_LSB   = 14;
  localparam int INFO_WINDOW_LSB = 12;
  localparam int INFO_AVG_LSB    = 0;

  // storage slots; the wear counter steps when the last slot is filled
  localparam logic [3:0] RECORD_SLOTS = 4'hA;

  // timing: one timestamp step is one second
  localparam int SECOND_NS       = 1000000000;
  localparam int CLK_PERIOD_NS   = 5;
  localparam int SECOND_CYCLES   = SECOND_NS / CLK_PERIOD_NS;

endpackage

//--- logic/record_info_register_bank.sv
// Purpose: register bank reached over the serial port, with link-side shifter
// Assumes: serial clock idles high, data taken on rising edge, driven on falling
// Notes:   a read answer appears in the frame that follows the read request

`timescale 1ns/1ps

module record_info_register_bank
  import record_info_pkg::*;
#(
  parameter int          SEC_CYCLES    = SECOND_CYCLES, // cycles per timestamp second
  parameter logic [15:0] PRODUCT_VALUE = 16'h1234,      // arbitrary identity value
  parameter logic [15:0] SERIAL_VALUE  = 16'h0001,      // arbitrary identity value
  parameter logic [15:0] DAY_AND_FIRMWARE_REVISION_BCD   = 16'h0110,      // day 01, revision 10
  parameter logic [15:0] YEAR_AND_MONTH_BCD  = 16'h2401       // year 24, month 01
) (
  input  wire logic       I_CLK_SYS,           // system clock
  input  wire logic       I_ARST_N,            // asynchronous reset, active low
  input  wire logic       I_SCLK,              // serial link clock
  input  wire logic       I_CS_N,              // serial chip select, active low
  input  wire logic       I_DIN,               // serial data in
  output logic            O_DOUT,              // serial data out
  output logic            O_DOUT_OE,           // data out enable
  input  wire logic       I_SYNC,              // external sync pin
  output logic            O_CAPTURE_START,     // capture request from sync pin
  output logic            O_SYNC_ENABLE,       // sync sensitivity level
  output logic            O_STATS_LOAD,        // flash to SRAM statistics pulse
  output logic            O_STATS_SAVE,        // SRAM to flash statistics pulse
  output logic            O_STATS_CLEAR,       // clear statistics pulse
  output logic            O_SELFTEST_ON,       // self test on pulse
  output logic            O_SELFTEST_CLEAR,    // self test off pulse
  input  wire logic       I_CAPTURE_DONE,      // capture event from capture engine
  input  wire logic       I_RECORDS_CLEARED,   // records cleared by global command
  input  wire logic [3:0] I_RECORD_COUNT,      // storage slots holding data
  input  wire logic       I_REC_STORE,         // new record stored in user buffer
  input  wire logic       I_REC_FFT_MODE,      // record came from an FFT mode
  input  wire logic [1:0] I_REC_SAMPLE_RATE,   // sample rate option of record
  input  wire logic [1:0] I_REC_WINDOW,        // window of record
  input  wire logic [7:0] I_REC_AVERAGES,      // FFT averages of record
  input  wire logic [3:0] I_REC_AVG_SETTING    // averaging count setting of record
);

  // elaboration checks on parameters
  function automatic logic bcd_ok(input logic [15:0] w);
    bcd_ok = (w[15:12] <= 4'h9) && (w[11:8] <= 4'h9) &&
             (w[7:4] <= 4'h9) && (w[3:0] <= 4'h9);
  endfunction

  initial begin
    if (SEC_CYCLES < 2 || SEC_CYCLES >= (1 << 28)) begin
      $error("SEC_CYCLES out of range");
    end
    if (!bcd_ok(DAY_AND_FIRMWARE_REVISION_BCD) || !bcd_ok(YEAR_AND_MONTH_BCD)) begin
      $error("date and revision must be BCD");
    end
  end

  // link clock domain
  logic        spi_clr;     // frame idle or reset
  logic [3:0]  bit_cnt;     // rising edges seen in this frame
  logic [14:0] shift_in;    // bits gathered so far
  logic [15:0] frame_word;  // last complete frame, held to next frame end
  logic        frame_tgl;   // flips once per complete frame
  logic [15:0] rd_word;     // answer word, system domain

  // the clear is combinational, so a select glitch can only restart the count
  assign spi_clr   = I_CS_N | ~I_ARST_N;
  // drive the line only while selected
  assign O_DOUT_OE = ~I_CS_N;

  // bit counter cleared by the frame's own select, so a cut frame is dropped
  always_ff @(posedge I_SCLK or posedge spi_clr) begin
    if (spi_clr) begin
      bit_cnt <= 4'h0;
    end else begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // shift in and publish a complete frame by toggling
  always_ff @(posedge I_SCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      shift_in   <= 15'h0000;
      frame_word <= RESET_WORD;
      frame_tgl  <= 1'b0;
    end else begin
      shift_in <= {shift_in[13:0], I_DIN};
      if (bit_cnt == 4'hF) begin   // sixteenth bit
        frame_word <= {shift_in, I_DIN};
        frame_tgl  <= ~frame_tgl;
      end
    end
  end

  // answer bits go out on falling edges; rd_word is settled long before the
  // next frame because it is loaded a few system cycles after a frame ends
  always_ff @(negedge I_SCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_DOUT <= 1'b0;
    end else begin
      O_DOUT <= rd_word[4'hF - bit_cnt];
    end
  end

  // system clock domain
  logic       req_s1, req_s2, req_s3; // frame toggle synchroniser
  logic       frame_evt;              // one pulse per received frame
  logic       sync_s1, sync_s2, sync_s3;
  logic       sync_rise;              // rising edge of the sync pin
  logic       is_wr;
  logic [6:0] addr;
  logic [7:0] wdata;

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
    end else begin
      req_s1 <= frame_tgl;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end

  // sync pin is outside our clock: two stages before the edge detector
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sync_s1 <= 1'b0;
      sync_s2 <= 1'b0;
      sync_s3 <= 1'b0;
    end else begin
      sync_s1 <= I_SYNC;
      sync_s2 <= sync_s1;
      sync_s3 <= sync_s2;
    end
  end

  assign frame_evt = req_s2 ^ req_s3;
  assign sync_rise = sync_s2 & ~sync_s3;
  // frame_word is stable here: no link edges come until the next frame
  assign is_wr = frame_word[FRAME_WR_BIT];
  assign addr  = frame_word[FRAME_ADDR_MSB:FRAME_ADDR_LSB];
  assign wdata = frame_word[7:0];

  // miscellaneous control: one stored bit and one-cycle action pulses
  logic wr_misc_lo, wr_misc_hi;
  assign wr_misc_lo = frame_evt && is_wr && (addr == ADDR_MISCELLANEOUS_CONTROL);
  assign wr_misc_hi = frame_evt && is_wr && (addr == (ADDR_MISCELLANEOUS_CONTROL | 7'h01));

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_SYNC_ENABLE    <= 1'b0;
      O_STATS_LOAD     <= 1'b0;
      O_STATS_SAVE     <= 1'b0;
      O_STATS_CLEAR    <= 1'b0;
      O_SELFTEST_ON    <= 1'b0;
      O_SELFTEST_CLEAR <= 1'b0;
    end else begin
      // writing zero to an action bit leaves the pulse low
      O_STATS_LOAD     <= wr_misc_hi && wdata[MISC_STATS_LOAD_BIT - 8];
      O_STATS_SAVE     <= wr_misc_hi && wdata[MISC_STATS_SAVE_BIT - 8];
      O_STATS_CLEAR    <= wr_misc_hi && wdata[MISC_STATS_CLEAR_BIT - 8];
      O_SELFTEST_ON    <= wr_misc_lo && wdata[MISC_SELFTEST_ON_BIT];
      O_SELFTEST_CLEAR <= wr_misc_lo && wdata[MISC_SELFTEST_CLR_BIT];
      if (wr_misc_hi) begin
        O_SYNC_ENABLE <= wdata[MISC_SYNC_EN_BIT - 8];
      end
    end
  end

  // capture from the sync pin only while enabled
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_CAPTURE_START <= 1'b0;
    end else begin
      O_CAPTURE_START <= sync_rise && O_SYNC_ENABLE;
    end
  end

  // seconds since reset; latched on each capture event
  logic [27:0] prescale;
  logic [31:0] seconds;
  logic [31:0] capture_time;

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      prescale <= 28'h0000000;
      seconds  <= 32'h00000000;
    end else if (prescale == 28'(SEC_CYCLES - 1)) begin
      prescale <= 28'h0000000;
      seconds  <= seconds + 32'h00000001;
    end else begin
      prescale <= prescale + 28'h0000001;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      capture_time <= 32'h00000000;
    end else if (I_CAPTURE_DONE) begin
      capture_time <= seconds;
    end
  end

  // wear counter: both events in one cycle count twice
  // the slot count is a same-clock level; only its step into the last slot counts
  logic [3:0]  prev_count;
  logic        fill_evt;
  logic [15:0] wear;

  assign fill_evt = (I_RECORD_COUNT == RECORD_SLOTS) && (prev_count != RECORD_SLOTS);

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      prev_count <= 4'h0;
      wear       <= RESET_WORD;
    end else begin
      prev_count <= I_RECORD_COUNT;
      wear       <= wear + 16'(I_RECORDS_CLEARED) + 16'(fill_evt);
    end
  end

  // spectral record info, kept only for FFT records, zero otherwise
  logic [15:0] info1;
  logic [15:0] info2;

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      info1 <= RESET_WORD;
      info2 <= RESET_WORD;
    end else if (I_REC_STORE) begin
      if (I_REC_FFT_MODE) begin
        info1 <= {I_REC_SAMPLE_RATE, I_REC_WINDOW, 4'h0, I_REC_AVERAGES};
        info2 <= {12'h000, I_REC_AVG_SETTING};
      end else begin
        info1 <= RESET_WORD;
        info2 <= RESET_WORD;
      end
    end
  end

  // read decode by word address; unmapped words read zero
  function automatic logic [15:0] reg_read(input logic [6:0] a);
    logic [6:0] w;
    w = {a[6:1], 1'b0};
    unique case (w)
      ADDR_CAPTURE_TIME_LOW:          reg_read = capture_time[15:0];
      ADDR_CAPTURE_TIME_HIGH:         reg_read = capture_time[31:16];
      ADDR_DAY_AND_FIRMWARE_REVISION: reg_read = DAY_AND_FIRMWARE_REVISION_BCD;
      ADDR_YEAR_AND_MONTH:            reg_read = YEAR_AND_MONTH_BCD;
      ADDR_PRODUCT_CODE:              reg_read = PRODUCT_VALUE;
      ADDR_UNIT_SERIAL:               reg_read = SERIAL_VALUE;
      ADDR_RECORD_FLASH_WEAR_COUNTER: reg_read = wear;
      ADDR_MISCELLANEOUS_CONTROL:
        reg_read = {3'h0, O_SYNC_ENABLE, 12'h000} & MISC_READ_MASK;
      ADDR_SPECTRAL_RECORD_SETTINGS:  reg_read = info1;
      ADDR_SPECTRAL_RECORD_AVG:       reg_read = info2;
      default:                        reg_read = RESET_WORD;
    endcase
  endfunction

  // answer word for the next frame; writes leave it unchanged
  // the link side reads this word with no synchroniser; the frame gap keeps it still
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rd_word <= RESET_WORD;
    end else if (frame_evt && !is_wr) begin
      rd_word <= reg_read(addr);
    end
  end

  // checks
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_ARST_N);

  a_wear_clear_step: assert property (
    I_RECORDS_CLEARED && !fill_evt |=> wear == $past(wear) + 16'h0001)
    else $error("wear counter missed a record clear");

  a_wear_fill_step: assert property (
    fill_evt && !I_RECORDS_CLEARED |=> wear == $past(wear) + 16'h0001)
    else $error("wear counter missed storage full");

  a_wear_quiet_hold: assert property (
    !I_RECORDS_CLEARED && !fill_evt |=> $stable(wear))
    else $error("wear counter moved without cause");

  a_sync_gated_start: assert property (
    O_CAPTURE_START |-> $past(O_SYNC_ENABLE) && $past(sync_s2) && !$past(sync_s3))
    else $error("capture start without enabled sync edge");

  a_stats_load_cmd: assert property (
    wr_misc_hi |=> O_STATS_LOAD == $past(wdata[2]) ##1 !O_STATS_LOAD)
    else $error("statistics load pulse wrong");

  a_stats_save_one: assert property (
    $rose(O_STATS_SAVE) |-> $past(wr_misc_hi) ##1 !O_STATS_SAVE)
    else $error("statistics save not a single pulse from a write");

  a_stats_clear_cmd: assert property (
    O_STATS_CLEAR |-> $past(wr_misc_hi) && $past(wdata[0]))
    else $error("statistics clear without a one written");

  a_selftest_cmd: assert property (
    wr_misc_lo |=> O_SELFTEST_ON == $past(wdata[3]) && O_SELFTEST_CLEAR == $past(wdata[2]))
    else $error("self test pulses wrong");

  a_time_capture: assert property (
    I_CAPTURE_DONE |=> capture_time == $past(seconds)
      ##1 $stable(capture_time) || $past(I_CAPTURE_DONE))
    else $error("timestamp not latched at capture");

  a_info_nonfft_zero: assert property (
    I_REC_STORE && !I_REC_FFT_MODE |=> info1 == RESET_WORD && info2 == RESET_WORD)
    else $error("record info kept for non FFT record");

  a_info_fields: assert property (
    I_REC_STORE && I_REC_FFT_MODE |=> info1[15:14] == $past(I_REC_SAMPLE_RATE)
      && info1[11:8] == 4'h0 && info2[15:4] == 12'h000)
    else $error("record info fields wrong");

  a_misc_read_zero: assert property (
    frame_evt && !is_wr && addr[6:1] == ADDR_MISCELLANEOUS_CONTROL[6:1]
      |=> rd_word == {3'h0, O_SYNC_ENABLE, 12'h000})
    else $error("unused control bits read nonzero");

  a_wear_both_step: assert property (
    I_RECORDS_CLEARED && fill_evt |=> wear == $past(wear) + 16'h0002)
    else $error("wear counter missed one of two events");

  a_sync_enable_write: assert property (
    wr_misc_hi |=> O_SYNC_ENABLE == $past(wdata[4]))
    else $error("sync enable not taken from the write");

  a_action_zero_idle: assert property (
    !wr_misc_hi |=> !O_STATS_LOAD && !O_STATS_SAVE && !O_STATS_CLEAR)
    else $error("statistics pulse without a control write");

  a_info_avg_copy: assert property (
    I_REC_STORE && I_REC_FFT_MODE |=> info1[13:12] == $past(I_REC_WINDOW)
      && info1[7:0] == $past(I_REC_AVERAGES) && info2[3:0] == $past(I_REC_AVG_SETTING))
    else $error("record averages or window not kept");

  a_frame_single_evt: assert property (
    frame_evt |=> !frame_evt)
    else $error("one frame decoded twice");

  c_sync_capture:  cover property (sync_rise && O_SYNC_ENABLE ##1 O_CAPTURE_START);
  c_wear_double:   cover property (I_RECORDS_CLEARED && fill_evt);
  c_storage_full:  cover property (fill_evt);
  c_read_frame:    cover property (frame_evt && !is_wr);
  c_misc_write:    cover property (wr_misc_hi ##1 O_STATS_SAVE);

endmodule

//--- test/host_link_model.sv
// Purpose: host end of the serial link, shifts frames and gathers answers
// Assumes: link clock idles high, host shifts on falling, samples on rising
// Notes:   link clock runs only inside a frame; idle data line is flipped
`timescale 1ns/1ps

module host_link_model (
  output logic      o_sclk,  // link clock, 80 ns period
  output logic      o_cs_n,  // chip select, active low
  output logic      o_din,   // host to device data
  input  wire logic i_dout   // device to host data
);
  // idle: clock high, device not selected
  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_din  = 1'b0;
  end

  // one 16-bit frame msb first; rx is the word shifted back meanwhile
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    o_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      #40 o_sclk = 1'b0;
      o_din  = tx[i];
      #40 o_sclk = 1'b1;
      rx[i]  = i_dout;
    end
    #40 o_cs_n = 1'b1;
    // flipped so a stale bit never looks like a held value
    o_din = ~o_din;
    // gap above 100 ns so the answer is loaded before the next frame
    #200;
  endtask
endmodule

//--- test/test_record_info_register_bank.sv
// Purpose: self-checking bench of the record information register bank
// Assumes: host model drives the link, bench drives the engine side
// Notes:   a ten-cycle second keeps timestamp checks short
`timescale 1ns/1ps

module test_record_info_register_bank
  import record_info_pkg::*;
();
  localparam int          SEC  = 10;       // cycles per timestamp second
  localparam logic [15:0] PROD = 16'h5A3C; // arbitrary identity value
  localparam logic [15:0] SERN = 16'h0042; // arbitrary identity value
  localparam logic [15:0] DREV = 16'h2713; // day 27, revision 13
  localparam logic [15:0] YMON = 16'h2309; // year 23, month 09
  localparam logic [6:0]  MISC = ADDR_MISCELLANEOUS_CONTROL;

  logic        clk_sys, arst_n, sclk, cs_n, din, dout, dout_oe, sync, rec_fft;
  logic        cap_st, sync_en, st_load, st_save, st_clr, self_on, self_clr;
  logic [2:0]  eng_p;                       // capture done, records cleared, store
  logic [3:0]  rec_cnt, rec_avg_set;
  logic [1:0]  rec_rate, rec_win;
  logic [7:0]  rec_avg;
  logic [5:0]  pulse_vec;
  logic [15:0] pcnt [6] = '{default: 16'h0000}; // pulse cycles seen
  logic [15:0] exp_p [6] = '{default: 16'h0000}; // pulse cycles expected
  logic [15:0] t0, t1;
  int          error_cnt, compares, cyc, c0, oe_bad;

  record_info_register_bank #(.SEC_CYCLES(SEC), .PRODUCT_VALUE(PROD),
    .SERIAL_VALUE(SERN), .DAY_AND_FIRMWARE_REVISION_BCD(DREV), .YEAR_AND_MONTH_BCD(YMON)) dut_u (
    .I_CLK_SYS(clk_sys), .I_ARST_N(arst_n), .I_SCLK(sclk), .I_CS_N(cs_n),
    .I_DIN(din), .O_DOUT(dout), .O_DOUT_OE(dout_oe), .I_SYNC(sync),
    .O_CAPTURE_START(cap_st), .O_SYNC_ENABLE(sync_en), .O_STATS_LOAD(st_load),
    .O_STATS_SAVE(st_save), .O_STATS_CLEAR(st_clr), .O_SELFTEST_ON(self_on),
    .O_SELFTEST_CLEAR(self_clr), .I_CAPTURE_DONE(eng_p[2]),
    .I_RECORDS_CLEARED(eng_p[1]), .I_RECORD_COUNT(rec_cnt), .I_REC_STORE(eng_p[0]),
    .I_REC_FFT_MODE(rec_fft), .I_REC_SAMPLE_RATE(rec_rate), .I_REC_WINDOW(rec_win),
    .I_REC_AVERAGES(rec_avg), .I_REC_AVG_SETTING(rec_avg_set));

  host_link_model host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout));

  // 200 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // cycle count and pulse tally; a stuck pulse shows as extra cycles
  assign pulse_vec = {cap_st, st_load, st_save, st_clr, self_on, self_clr};
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    for (int k = 0; k < 6; k++) if (pulse_vec[k] === 1'b1) pcnt[k] <= pcnt[k] + 16'h0001;
  end

  // output enable must stand high at every falling link edge of a frame
  always @(negedge sclk) begin
    if (dout_oe !== 1'b1) oe_bad <= oe_bad + 1;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask

  // one-cycle pulse on the engine side inputs
  task automatic pulse(input logic [2:0] m);
    tick();
    eng_p = m;
    tick();
    eng_p = 3'h0;
  endtask

  // frames start off the system edge, so the two clocks stay unrelated
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    @(posedge clk_sys);
    #1.7;
    host_u.xfer(tx, rx);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] rx;
    frame({1'b1, a, d}, rx);
  endtask

  // the answer to a read comes back in the following frame
  task automatic rd(input logic [6:0] a, output logic [15:0] q);
    frame({1'b0, a, 8'h00}, q);
    frame({1'b0, 7'h00, 8'h00}, q);
  endtask

  task automatic rd_chk(input string what, input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] q;
    rd(a, q);
    chk(what, exp, q);
  endtask

  // adds the expected new pulses, then compares all six tallies
  task automatic chk_p(input logic [5:0] inc);
    for (int k = 0; k < 6; k++) begin
      exp_p[k] = exp_p[k] + {15'h0000, inc[k]};
      chk($sformatf("pulse_cycles_%0d", k), exp_p[k], pcnt[k]);
    end
  endtask

  // sync pin held three cycles, then time for the two-flop path
  task automatic sync_pulse();
    tick();
    sync = 1'b1;
    repeat (3) tick();
    sync = 1'b0;
    repeat (8) tick();
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // a hang counts as a mismatch and ends in the closing report
  initial begin
    #400000;
    error_cnt++;
    $display("ERROR run_time expected finish seen timeout");
    test_done();
  end

  initial begin
    {arst_n, sync, eng_p, rec_fft, rec_cnt, rec_avg_set, rec_rate, rec_win, rec_avg} = '0;
    error_cnt = 0;
    compares = 0;
    cyc = 0;
    repeat (12) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    // reset values, identity words, odd byte, unmapped place, dropped writes
    rd_chk("time_low", ADDR_CAPTURE_TIME_LOW, RESET_WORD);
    rd_chk("day_and_firmware_revision", ADDR_DAY_AND_FIRMWARE_REVISION, DREV);
    rd_chk("year_and_month", ADDR_YEAR_AND_MONTH, YMON);
    rd_chk("serial", ADDR_UNIT_SERIAL, SERN);
    rd_chk("misc", MISC, RESET_WORD);
    rd_chk("info2", ADDR_SPECTRAL_RECORD_AVG, RESET_WORD);
    rd_chk("unmapped", 7'h10, RESET_WORD);
    wr(ADDR_PRODUCT_CODE, 8'hFF);
    wr(ADDR_SPECTRAL_RECORD_SETTINGS, 8'hFF);
    rd_chk("product", ADDR_PRODUCT_CODE + 7'h01, PROD);
    rd_chk("info1", ADDR_SPECTRAL_RECORD_SETTINGS, RESET_WORD);
    $display("test reset_values done");
    // two captures a whole number of seconds apart
    c0 = cyc;
    pulse(3'h4);
    rd(ADDR_CAPTURE_TIME_LOW, t0);
    for (int k = 0; k < SEC && ((cyc - c0) % SEC) != 0; k++) tick();
    t1 = 16'((cyc - c0) / SEC);
    pulse(3'h4);
    rd_chk("time_step", ADDR_CAPTURE_TIME_LOW, t0 + t1);
    rd_chk("time_high", ADDR_CAPTURE_TIME_HIGH, RESET_WORD);
    $display("test timestamp done");
    // clear command, fill edge, held full, refill, then both in one cycle
    pulse(3'h2);
    rd_chk("wear_clear", ADDR_RECORD_FLASH_WEAR_COUNTER, 16'h0001);
    rec_cnt = 4'h9;
    tick();
    rec_cnt = RECORD_SLOTS;
    repeat (3) tick();
    rec_cnt = 4'h0;
    tick();
    rec_cnt = RECORD_SLOTS;
    tick();
    rec_cnt = 4'h0;
    tick();
    rec_cnt = RECORD_SLOTS;
    eng_p = 3'h2;
    tick();
    eng_p = 3'h0;
    rd_chk("wear_full", ADDR_RECORD_FLASH_WEAR_COUNTER, 16'h0005);
    $display("test wear done");
    // each action bit pulses once; zeros do nothing; only bit 12 reads back
    wr(MISC + 7'h01, 8'h07);
    wr(MISC, 8'h0C);
    chk_p(6'b011111);
    wr(MISC, 8'h00);
    wr(MISC + 7'h01, 8'h10);
    chk_p(6'b000000);
    chk("sync_enable", 16'h0001, {15'h0000, sync_en});
    sync_pulse();
    chk_p(6'b100000);
    wr(MISC + 7'h01, 8'hFF);
    wr(MISC, 8'hFF);
    chk_p(6'b011111);
    rd_chk("misc_set", MISC, 16'h1000);
    wr(MISC + 7'h01, 8'h00);
    sync_pulse();
    chk_p(6'b000000);
    rd_chk("misc_off", MISC, RESET_WORD);
    $display("test control done");
    // every rate and window code; then a record from another mode
    for (int r = 0; r < 5; r++) begin
      rec_rate = 2'(r);
      rec_win = 2'(3 - r);
      rec_avg = 8'(r * 84 + 1);
      rec_avg_set = 4'(r + 9);
      rec_fft = (r < 4);
      pulse(3'h1);
      rd_chk("info1", ADDR_SPECTRAL_RECORD_SETTINGS,
             (r < 4) ? {rec_rate, rec_win, 4'h0, rec_avg} : RESET_WORD);
      rd_chk("info2", ADDR_SPECTRAL_RECORD_AVG,
             (r < 4) ? {12'h000, rec_avg_set} : RESET_WORD);
    end
    chk("dout_oe_frames", 16'h0000, 16'(oe_bad));
    chk("dout_oe_idle", 16'h0000, {15'h0000, dout_oe});
    $display("test record_info done");
    test_done();
  end
endmodule
